// ---- include/sdlp_pkg.sv ----
// package for the static digital line port: register map and encodings
package sdlp_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] SDLP_OFF_DIR    = 8'h00;
  localparam logic [7:0] SDLP_OFF_OC     = 8'h04;
  localparam logic [7:0] SDLP_OFF_DOUT   = 8'h08;
  localparam logic [7:0] SDLP_OFF_DIN    = 8'h0C;
  localparam logic [7:0] SDLP_OFF_CFG    = 8'h10;
  localparam logic [7:0] SDLP_OFF_P4     = 8'h14;

  // ****************************************
  // widths, fields and reset values
  // ****************************************
  localparam int SDLP_NLINES = 32;
  localparam int SDLP_P4W    = 4;
  localparam int SDLP_CFG_PULL_BIT = 0;
  localparam int SDLP_CFG_G1_BIT   = 1;
  localparam int SDLP_CFG_G2_BIT   = 2;
  localparam logic [31:0] SDLP_RST_DIR  = 32'h0000_0000;
  localparam logic [31:0] SDLP_RST_OC   = 32'h0000_0000;
  localparam logic [31:0] SDLP_RST_DOUT = 32'h0000_0000;
  localparam logic [2:0]  SDLP_RST_CFG  = 3'h0;
  localparam logic [3:0]  SDLP_RST_P4   = 4'h0;

  // per-line driver mode
  typedef enum logic [1:0] {
    SDLP_MODE_IN = 2'b00,
    SDLP_MODE_PP = 2'b01,
    SDLP_MODE_OC = 2'b11
  } sdlp_mode_t;

endpackage

// ---- rtl/sdlp_top.sv ----
// static digital line port: APB registers, 32 data lines, 4-bit control port
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module sdlp_top
  import sdlp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // data lines
  input  wire logic [31:0] data_in,
  output logic      [31:0] data_out,
  output logic      [31:0] data_oe,
  output logic             data_pull_select,
  // control lines of the two timing groups
  input  wire logic [3:0]  ctl_in,
  output logic      [3:0]  ctl_out,
  output logic      [3:0]  ctl_oe,
  // groups taken by pattern or handshake transfers
  input  wire logic        grp1_busy,
  input  wire logic        grp2_busy
);

  // ****************************************
  // reset release
  // ****************************************
  // the core leaves reset two edges after resetn rises
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] dir_q,  dir_d;
  logic [31:0] oc_q,   oc_d;
  logic [31:0] dout_q, dout_d;
  // cfg bits 2:1 are kept for software only and drive nothing
  logic [2:0]  cfg_q,  cfg_d;
  logic [3:0]  p4_q,   p4_d;
  logic [31:0] din_q,  din_d;
  logic [3:0]  p4in_q, p4in_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        err_q,   err_d;
  logic [31:0] dout_pin_q, dout_pin_d;
  logic [31:0] doe_q,      doe_d;
  logic [3:0]  cout_q,     cout_d;
  logic [3:0]  coe_q,      coe_d;

  // line mode from the two configuration bits
  function automatic sdlp_mode_t line_mode(input logic d, input logic oc);
    if (!d)
      return SDLP_MODE_IN;
    else if (oc)
      return SDLP_MODE_OC;
    else
      return SDLP_MODE_PP;
  endfunction

  // every mapped offset; anything else is answered with an error
  function automatic logic addr_ok(input logic [7:0] a);
    return (a == SDLP_OFF_DIR) || (a == SDLP_OFF_OC) ||
           (a == SDLP_OFF_DOUT) || (a == SDLP_OFF_DIN) ||
           (a == SDLP_OFF_CFG) || (a == SDLP_OFF_P4);
  endfunction

  // ****************************************
  // apb access
  // ****************************************
  // the answer comes one cycle into the access phase and reads are taken
  // then; a write lands only at the edge that completes the transfer, so
  // a request dropped before pready never changes a register
  logic acc;
  logic wr_en;
  logic [1:0] grp_busy;
  assign acc = psel && penable && !ready_q;
  assign wr_en = psel && penable && pwrite && ready_q;
  assign grp_busy = {grp2_busy, grp1_busy};

  always_comb begin
    dir_d   = dir_q;
    oc_d    = oc_q;
    dout_d  = dout_q;
    cfg_d   = cfg_q;
    p4_d    = p4_q;
    rdata_d = rdata_q;
    err_d   = 1'b0;
    ready_d = acc;
    // pins are sampled every cycle, so a read shows them one cycle late
    din_d   = data_in;
    // busy groups keep their last static input value
    p4in_d  = p4in_q;
    if (!grp_busy[0]) p4in_d[1:0] = ctl_in[1:0];
    if (!grp_busy[1]) p4in_d[3:2] = ctl_in[3:2];
    if (acc) begin
      err_d = !addr_ok(paddr);
      if (!pwrite) begin
        unique case (paddr)
          SDLP_OFF_DIR:  rdata_d = dir_q;
          SDLP_OFF_OC:   rdata_d = oc_q;
          SDLP_OFF_DOUT: rdata_d = dout_q;
          SDLP_OFF_DIN:  rdata_d = din_q;
          SDLP_OFF_CFG:  rdata_d = {29'h0, cfg_q};
          SDLP_OFF_P4:   rdata_d = {28'h0, p4in_q};
          // unmapped reads give zero
          default:       rdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (wr_en) begin
      unique case (paddr)
        SDLP_OFF_DIR:  dir_d  = pwdata;
        SDLP_OFF_OC:   oc_d   = pwdata;
        SDLP_OFF_DOUT: dout_d = pwdata;
        SDLP_OFF_CFG:  cfg_d  = pwdata[2:0];
        SDLP_OFF_P4:   p4_d   = pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always_comb begin
    // a released line takes its level from the pull or the far side
    for (int i = 0; i < SDLP_NLINES; i++) begin
      unique case (line_mode(dir_q[i], oc_q[i]))
        SDLP_MODE_PP: begin
          dout_pin_d[i] = dout_q[i];
          doe_d[i]      = 1'b1;
        end
        SDLP_MODE_OC: begin
          dout_pin_d[i] = 1'b0;
          doe_d[i]      = !dout_q[i];
        end
        default: begin
          dout_pin_d[i] = 1'b0;
          doe_d[i]      = 1'b0;
        end
      endcase
    end
    // the reused outputs have no enable bit: they drive whenever their
    // group is free, and a busy group takes its pair back
    cout_d = p4_q;
    coe_d  = {{2{!grp_busy[1]}}, {2{!grp_busy[0]}}};
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      dir_q      <= SDLP_RST_DIR;
      oc_q       <= SDLP_RST_OC;
      dout_q     <= SDLP_RST_DOUT;
      cfg_q      <= SDLP_RST_CFG;
      p4_q       <= SDLP_RST_P4;
      din_q      <= 32'h0000_0000;
      p4in_q     <= 4'h0;
      rdata_q    <= 32'h0000_0000;
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
      dout_pin_q <= 32'h0000_0000;
      doe_q      <= 32'h0000_0000;
      cout_q     <= 4'h0;
      coe_q      <= 4'h0;
    end else begin
      dir_q      <= dir_d;
      oc_q       <= oc_d;
      dout_q     <= dout_d;
      cfg_q      <= cfg_d;
      p4_q       <= p4_d;
      din_q      <= din_d;
      p4in_q     <= p4in_d;
      rdata_q    <= rdata_d;
      ready_q    <= ready_d;
      err_q      <= err_d;
      dout_pin_q <= dout_pin_d;
      doe_q      <= doe_d;
      cout_q     <= cout_d;
      coe_q      <= coe_d;
    end
  end

  assign prdata           = rdata_q;
  assign pready           = ready_q;
  assign pslverr          = err_q;
  assign data_out         = dout_pin_q;
  assign data_oe          = doe_q;
  assign data_pull_select = cfg_q[SDLP_CFG_PULL_BIT];
  assign ctl_out          = cout_q;
  assign ctl_oe           = coe_q;

endmodule

// ---- dv/sdlp_pins.sv ----
// model of the pins and the far-side device on the 32 data lines
`timescale 1ns/1ps
module sdlp_pins (
  // pad side of the block
  input  wire logic [31:0] data_out,
  input  wire logic [31:0] data_oe,
  input  wire logic        data_pull_select,
  // far-side open-collector drivers, 1 = hold the line low
  input  wire logic [31:0] ext_low,
  output logic      [31:0] data_in
);
  // an undriven line follows the weak pull, never its last value
  assign data_in = ((data_oe & data_out) | (~data_oe & {32{data_pull_select}}))
                   & ~ext_low;
endmodule

// ---- dv/sdlp_monitor.sv ----
// checker watching the ports of the static digital line port
`timescale 1ns/1ps
module sdlp_monitor
  import sdlp_pkg::*;
(
  // clock, reset and apb
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [31:0] data_in,
  input wire logic [31:0] data_oe,
  input wire logic        data_pull_select,
  input wire logic [3:0]  ctl_out,
  input wire logic [3:0]  ctl_oe,
  // group state
  input wire logic        grp1_busy,
  input wire logic        grp2_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ready; $rose(penable) && psel |-> ##[0:1] pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer");
  property p_in; pready && pwrite && paddr == SDLP_OFF_DIR
    |=> ##1 (data_oe & ~$past(pwdata, 2)) == 32'h0; endproperty
  a_in: assert property (p_in) else $error("input driven");
  property p_pull; pready && pwrite && paddr == SDLP_OFF_CFG
    |=> ##1 data_pull_select == $past(pwdata[0], 2); endproperty
  a_pull: assert property (p_pull) else $error("pull wrong");
  property p_busy1; grp1_busy [*2] |-> ctl_oe[1:0] == 2'h0; endproperty
  a_busy1: assert property (p_busy1) else $error("grp1 out");
  property p_busy2; grp2_busy [*2] |-> ctl_oe[3:2] == 2'h0; endproperty
  a_busy2: assert property (p_busy2) else $error("grp2 out");
  property p_own; (!grp1_busy && !grp2_busy) [*4] |-> ctl_oe == 4'hF;
  endproperty
  a_own: assert property (p_own) else $error("port4 not out");
  property p_p4; pready && pwrite && paddr == SDLP_OFF_P4 && !grp1_busy
    && !grp2_busy |=> ##1 ((ctl_out ^ $past(pwdata[3:0], 2)) & ctl_oe) == 4'h0;
  endproperty
  a_p4: assert property (p_p4) else $error("port4 out");
  property p_din; pready && !pwrite && paddr == SDLP_OFF_DIN && $stable(data_in)
    && $past(data_in, 2) == data_in |-> prdata == data_in; endproperty
  a_din: assert property (p_din) else $error("din wrong");
  property p_err; pready && paddr > SDLP_OFF_P4 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
endmodule
bind sdlp_top sdlp_monitor i_sdlp_monitor (.*);

// ---- dv/sdlp_top_test.sv ----
// testbench for the static digital line port
`timescale 1ns/1ps
module sdlp_top_test;
  import sdlp_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic grp1_busy = 0, grp2_busy = 0, pready, pslverr, data_pull_select;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, data_in, data_out, data_oe, r;
  logic [31:0] ext_low = 32'h0;
  logic        rsp_err;
  logic [3:0]  ctl_in = 4'h0, ctl_out, ctl_oe;
  int fails = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  sdlp_top i_sdlp_top (.*);
  sdlp_pins i_sdlp_pins (.*);
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    rsp_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // pins settle a cycle after the register edge, so wait a little
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic t_lines;
    rd(SDLP_OFF_DIR, SDLP_RST_DIR);
    chk(data_oe, 32'h0);
    wr(SDLP_OFF_DIR, 32'hFFFF_FFFF);
    wr(SDLP_OFF_DOUT, 32'hA5A5_0F0F);
    for (int p = 0; p < 2; p++) begin
      wr(SDLP_OFF_CFG, 32'(p));
      chk(data_in, 32'hA5A5_0F0F);
    end
    wr(SDLP_OFF_OC, 32'hFFFF_0000);
    wr(SDLP_OFF_DOUT, 32'h5555_5555);
    chk(data_oe, 32'hAAAA_FFFF);
    chk(data_out, 32'h0000_5555);
    ext_low <= 32'h0001_0000;
    rd(SDLP_OFF_DIN, 32'h5554_5555);
    wr(SDLP_OFF_CFG, 32'h0);
    chk(data_in, 32'h0000_5555);
    chk(32'(data_pull_select), 32'h0);
    wr(SDLP_OFF_DIR, 32'h0000_FFFF);
    chk(data_oe, 32'h0000_FFFF);
    wr(SDLP_OFF_CFG, 32'h1);
    rd(SDLP_OFF_DIN, 32'hFFFE_5555);
    $display("data line test done");
  endtask
  task automatic t_port4;
    chk(32'(ctl_oe), 32'h0000_000F);
    wr(SDLP_OFF_CFG, 32'h0000_0006);
    wr(SDLP_OFF_P4, 32'h0000_000A);
    chk(32'({ctl_oe, ctl_out}), 32'h0000_00FA);
    ctl_in <= 4'h5;
    rd(SDLP_OFF_P4, 32'h0000_0005);
    grp1_busy <= 1;
    repeat (2) @(posedge clk);
    chk(32'(ctl_oe), 32'h0000_000C);
    grp2_busy <= 1;
    repeat (2) @(posedge clk);
    chk(32'(ctl_oe), 32'h0);
    ctl_in <= 4'hA;
    rd(SDLP_OFF_P4, 32'h0000_0005);
    rd(8'h3C, 32'h0);
    chk(32'(rsp_err), 32'h1);
    $display("port4 test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    repeat (3) @(posedge clk);
    t_lines;
    t_port4;
    stop_test;
  end
  initial begin
    #50us;
    fails++;
    stop_test;
  end
endmodule
